// ---- rtl/flash_protect_defines.vh ----
`ifndef FLASH_PROTECT_DEFINES_VH
`define FLASH_PROTECT_DEFINES_VH

// Register byte offsets on the 32-bit bus.
`define CFG_OFFSET          4'h0
`define PROT_OFFSET         4'h4
`define STAT_OFFSET         4'h8
`define TEST_OFFSET         4'hc

// Configuration register fields.
`define CFG_BE_IE_BIT       7
`define CFG_CC_IE_BIT       6
`define CFG_KEY_MODE_BIT    5
`define CFG_BANK_SEL_BIT    0
`define CFG_RESET           8'h00

// Protection register fields.
`define PROT_OPEN_BIT       7
`define PROT_RSV_BIT        6
`define PROT_HDIS_BIT       5
`define PROT_HSIZE_HI       4
`define PROT_HSIZE_LO       3
`define PROT_LDIS_BIT       2
`define PROT_LSIZE_HI       1
`define PROT_LSIZE_LO       0

// Flash addresses of the protection bytes loaded at reset.
`define NV_PROT_BLK0_ADDR   16'hff0d
`define NV_PROT_BLK1_ADDR   16'hff0c

// Status register fields.
`define STAT_BE_BIT         7
`define STAT_CC_BIT         6
`define STAT_PROTECTION_VIOLATION_FLAG_BIT      5

// Test register field.
`define TEST_BANK_WRITE_ALL_BIT      4

// Enabled encoding of the backdoor key enable field.
`define KEY_ENABLED         2'h2

// Protection range fixed ends: top of the high range, base of the low range.
`define HIGH_TOP            16'hffff
`define LOW_BASE            16'h4000

// Allowed target scenarios per source scenario, bit n = scenario n.
`define SCEN_ALLOW_0        8'h0f
`define SCEN_ALLOW_1        8'h0a
`define SCEN_ALLOW_2        8'h0c
`define SCEN_ALLOW_3        8'h08
`define SCEN_ALLOW_4        8'h18
`define SCEN_ALLOW_5        8'h3c
`define SCEN_ALLOW_6        8'h5a
`define SCEN_ALLOW_7        8'hff

`endif

// ---- rtl/flash_protect_config.v ----
`timescale 1ns/1ps
`include "flash_protect_defines.vh"

module flash_protect_config
(
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [3:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	input  wire        special_mode_i,
	input  wire [1:0]  backdoor_key_enable_i,
	input  wire [7:0]  nv_prot_blk0_i,
	input  wire [7:0]  nv_prot_blk1_i,
	input  wire [1:0]  buffer_empty_flag_i,
	input  wire [1:0]  cmd_complete_flag_i,
	input  wire        array_write_i,
	input  wire        cmd_valid_i,
	input  wire        cmd_block_i,
	input  wire        cmd_mass_i,
	input  wire [15:0] cmd_addr_i,
	output reg         cmd_accept_o,
	output reg         cmd_refuse_o,
	output reg         cmd_seq_start_o,
	output reg         key_write_o,
	output reg         array_read_invalid_o,
	output reg         irq_o
);

	reg  [7:0] cfg;
	reg  [7:0] prot0;
	reg  [7:0] prot1;
	reg  [1:0] protection_violation_flag;
	reg        bank_write_all;
	reg  [7:0] next_prot0;
	reg  [7:0] next_prot1;
	reg  [7:0] rd_byte;
	wire       access;
	wire       wr;
	wire       bank;
	wire [7:0] sel_prot;
	wire       hit_prot;
	wire [7:0] blk_prot;
	wire       wr_this0;
	wire       wr_this1;
	wire       be_req;
	wire       cc_req;

	// Scenario index is the mode bit and the two range disable bits.
	function [2:0] scenario;
		input [7:0] p;
		begin
			scenario = {p[`PROT_OPEN_BIT], p[`PROT_HDIS_BIT], p[`PROT_LDIS_BIT]};
		end
	endfunction

	// Returns one when moving from scenario f to scenario t adds protection only.
	function allowed;
		input [2:0] f;
		input [2:0] t;
		reg   [7:0] row;
		begin
			row = `SCEN_ALLOW_7;
			case (f)
				3'd0: row = `SCEN_ALLOW_0;
				3'd1: row = `SCEN_ALLOW_1;
				3'd2: row = `SCEN_ALLOW_2;
				3'd3: row = `SCEN_ALLOW_3;
				3'd4: row = `SCEN_ALLOW_4;
				3'd5: row = `SCEN_ALLOW_5;
				3'd6: row = `SCEN_ALLOW_6;
				default: row = `SCEN_ALLOW_7;
			endcase
			allowed = row[t];
		end
	endfunction

	// Builds the new protection value from old value and written byte.
	function [7:0] merge_prot;
		input [7:0] old;
		input [7:0] w;
		reg   [7:0] cand;
		begin
			// Size fields obey the disable bits as they stood before the write.
			cand = w;
			cand[`PROT_RSV_BIT] = old[`PROT_RSV_BIT];
			if (!old[`PROT_HDIS_BIT])
			begin
				cand[`PROT_HSIZE_HI:`PROT_HSIZE_LO] = old[`PROT_HSIZE_HI:`PROT_HSIZE_LO];
			end
			if (!old[`PROT_LDIS_BIT])
			begin
				cand[`PROT_LSIZE_HI:`PROT_LSIZE_LO] = old[`PROT_LSIZE_HI:`PROT_LSIZE_LO];
			end
			if (allowed(scenario(old), scenario(cand)))
			begin
				merge_prot = cand;
			end
			else
			begin
				merge_prot = old;
			end
		end
	endfunction

	// Returns one when an unpaged address is protected by setting p.
	function is_protected;
		input [7:0]  p;
		input [15:0] a;
		reg   [15:0] hbase;
		reg   [15:0] ltop;
		reg          in_hi;
		reg          in_lo;
		begin
			case (p[`PROT_HSIZE_HI:`PROT_HSIZE_LO])
				2'd0: hbase = 16'hf800;
				2'd1: hbase = 16'hf000;
				2'd2: hbase = 16'he000;
				default: hbase = 16'hc000;
			endcase
			case (p[`PROT_LSIZE_HI:`PROT_LSIZE_LO])
				2'd0: ltop = 16'h43ff;
				2'd1: ltop = 16'h47ff;
				2'd2: ltop = 16'h4fff;
				default: ltop = 16'h5fff;
			endcase
			in_hi = !p[`PROT_HDIS_BIT] && (a >= hbase) && (a <= `HIGH_TOP);
			in_lo = !p[`PROT_LDIS_BIT] && (a >= `LOW_BASE) && (a <= ltop);
			if (p[`PROT_OPEN_BIT])
			begin
				is_protected = in_hi | in_lo;
			end
			else
			begin
				is_protected = !(in_hi | in_lo);
			end
		end
	endfunction

	// Bus decode: the access is taken on the edge that raises ack.
	assign access   = cyc_i & stb_i & ~ack_o;
	// Only the low byte lane holds a register, so sel_i[0] gates every write.
	assign wr       = access & we_i & sel_i[0];
	assign bank     = cfg[`CFG_BANK_SEL_BIT];
	assign sel_prot = bank ? prot1 : prot0;
	assign hit_prot = wr && (adr_i == `PROT_OFFSET);
	assign wr_this0 = bank_write_all | ~bank;
	assign wr_this1 = bank_write_all | bank;
	assign blk_prot = cmd_block_i ? prot1 : prot0;

	// Interrupt conditions of the two flag kinds, ahead of the output register.
	// buffer empty request
	assign be_req   = cfg[`CFG_BE_IE_BIT] & (|buffer_empty_flag_i);
	assign cc_req   = cfg[`CFG_CC_IE_BIT] & (|cmd_complete_flag_i);

	// Next protection values for both banks.
	always @*
	begin
		next_prot0 = prot0;
		next_prot1 = prot1;
		if (hit_prot && wr_this0)
		begin
			next_prot0 = merge_prot(prot0, dat_i[7:0]);
		end
		if (hit_prot && wr_this1)
		begin
			next_prot1 = merge_prot(prot1, dat_i[7:0]);
		end
	end

	// Read multiplexer; unmapped offsets read zero.
	always @*
	begin
		rd_byte = 8'h00;
		if (adr_i == `CFG_OFFSET)
		begin
			rd_byte = cfg;
		end
		else if (adr_i == `PROT_OFFSET)
		begin
			rd_byte = sel_prot;
		end
		else if (adr_i == `STAT_OFFSET)
		begin
			// Status shows the flags of the selected bank only.
			rd_byte[`STAT_BE_BIT]    = buffer_empty_flag_i[bank];
			rd_byte[`STAT_CC_BIT]    = cmd_complete_flag_i[bank];
			rd_byte[`STAT_PROTECTION_VIOLATION_FLAG_BIT] = protection_violation_flag[bank];
		end
		else if (adr_i == `TEST_OFFSET)
		begin
			rd_byte[`TEST_BANK_WRITE_ALL_BIT] = bank_write_all;
		end
	end

	// Bus answer: one wait state, ack dropped the cycle after.
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end
		else
		begin
			// A request still held while ack is high is not taken a second time.
			ack_o <= access;
			if (access)
			begin
				dat_o <= {24'h000000, rd_byte};
			end
		end
	end

	// Configuration and test registers.
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cfg   <= `CFG_RESET;
			bank_write_all <= 1'b0;
		end
		else
		begin
			if (wr && (adr_i == `CFG_OFFSET))
			begin
				cfg[`CFG_BE_IE_BIT]    <= dat_i[`CFG_BE_IE_BIT];
				cfg[`CFG_CC_IE_BIT]    <= dat_i[`CFG_CC_IE_BIT];
				cfg[`CFG_BANK_SEL_BIT] <= dat_i[`CFG_BANK_SEL_BIT];
				// Bits 4 to 1 are never stored and keep reading zero.
				// key mode gating
				if (backdoor_key_enable_i == `KEY_ENABLED)
				begin
					cfg[`CFG_KEY_MODE_BIT] <= dat_i[`CFG_KEY_MODE_BIT];
				end
			end
			if (wr && (adr_i == `TEST_OFFSET) && special_mode_i)
			begin
				bank_write_all <= dat_i[`TEST_BANK_WRITE_ALL_BIT];
			end
		end
	end

	// Protection registers; reset reloads the nonvolatile bytes.
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			// A held reset reloads the bytes on every edge, so late changes land.
			// reset load
			prot0 <= nv_prot_blk0_i;
			prot1 <= nv_prot_blk1_i;
		end
		else
		begin
			prot0 <= next_prot0;
			prot1 <= next_prot1;
		end
	end

	// Command check and violation flags; a set beats a same-cycle clear.
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			protection_violation_flag        <= 2'b00;
			cmd_accept_o <= 1'b0;
			cmd_refuse_o <= 1'b0;
		end
		else
		begin
			cmd_accept_o <= 1'b0;
			cmd_refuse_o <= 1'b0;
			if (wr && (adr_i == `STAT_OFFSET) && dat_i[`STAT_PROTECTION_VIOLATION_FLAG_BIT])
			begin
				if (wr_this0)
				begin
					protection_violation_flag[0] <= 1'b0;
				end
				if (wr_this1)
				begin
					protection_violation_flag[1] <= 1'b0;
				end
			end
			if (cmd_valid_i)
			begin
				if (cmd_mass_i && (!blk_prot[`PROT_OPEN_BIT] ||
					!blk_prot[`PROT_HDIS_BIT] || !blk_prot[`PROT_LDIS_BIT]))
				begin
					cmd_refuse_o       <= 1'b1;
					protection_violation_flag[cmd_block_i] <= 1'b1;
				end
				// A flag set here outlives a clear written in the same cycle.
				// protected area refused
				else if (!cmd_mass_i && is_protected(blk_prot, cmd_addr_i))
				begin
					cmd_refuse_o       <= 1'b1;
					protection_violation_flag[cmd_block_i] <= 1'b1;
				end
				else
				begin
					cmd_accept_o <= 1'b1;
				end
			end
		end
	end

	// Array access steering and interrupt request.
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cmd_seq_start_o      <= 1'b0;
			key_write_o          <= 1'b0;
			array_read_invalid_o <= 1'b0;
			irq_o                <= 1'b0;
		end
		else
		begin
			cmd_seq_start_o      <= array_write_i & ~cfg[`CFG_KEY_MODE_BIT];
			key_write_o          <= array_write_i & cfg[`CFG_KEY_MODE_BIT];
			// Array reads stay flagged invalid for as long as key mode is on.
			array_read_invalid_o <= cfg[`CFG_KEY_MODE_BIT];
			irq_o                <= be_req | cc_req;
		end
	end

endmodule // flash_protect_config

// ---- test/flash_protect_config_props.sv ----
`timescale 1ns/1ps
// Watches the bus, command and steering outputs of the protection block.
module flash_protect_config_props
(
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [3:0] adr_i,
	input wire [31:0] dat_o,
	input wire ack_o,
	input wire [1:0] buffer_empty_flag_i,
	input wire [1:0] cmd_complete_flag_i,
	input wire array_write_i,
	input wire cmd_valid_i,
	input wire cmd_accept_o,
	input wire cmd_refuse_o,
	input wire cmd_seq_start_o,
	input wire key_write_o,
	input wire array_read_invalid_o,
	input wire irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	reg cfg_wr;
	// Remembers a configuration write answered in the previous cycle.
	always @(posedge clk_i)
		cfg_wr <= ack_o && we_i && adr_i == 4'h0;
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_ack;
		ack_o ##1 !ack_o;
	endsequence
	AST_ACK_NEXT: assert property (s_req |=> s_ack) else $error("ack late");
	AST_DAT_HIGH: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("dat");
	AST_CMD_ONE: assert property (cmd_valid_i |=> cmd_accept_o != cmd_refuse_o)
		else $error("cmd answer");
	AST_CMD_QUIET: assert property (!cmd_valid_i |=> !cmd_accept_o && !cmd_refuse_o)
		else $error("cmd spurious");
	AST_STEER: assert property (array_write_i |=> key_write_o == array_read_invalid_o
		&& cmd_seq_start_o != array_read_invalid_o) else $error("steer");
	AST_STEER_QUIET: assert property (!array_write_i |=> !key_write_o && !cmd_seq_start_o)
		else $error("steer spurious");
	AST_IRQ_LOW: assert property (buffer_empty_flag_i == 2'h0 && cmd_complete_flag_i == 2'h0
		|=> !irq_o) else $error("irq");
	AST_KEY_CAUSE: assert property ($changed(array_read_invalid_o) |-> cfg_wr)
		else $error("key mode");
endmodule // flash_protect_config_props
bind flash_protect_config flash_protect_config_props flash_protect_config_props_i (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.dat_o(dat_o), .ack_o(ack_o), .buffer_empty_flag_i(buffer_empty_flag_i),
	.cmd_complete_flag_i(cmd_complete_flag_i), .array_write_i(array_write_i),
	.cmd_valid_i(cmd_valid_i), .cmd_accept_o(cmd_accept_o), .cmd_refuse_o(cmd_refuse_o),
	.cmd_seq_start_o(cmd_seq_start_o), .key_write_o(key_write_o),
	.array_read_invalid_o(array_read_invalid_o), .irq_o(irq_o));

// ---- test/cpu_model.sv ----
`timescale 1ns/1ps
// CPU core model: one classic bus cycle per call of bus.
module cpu_model
(
	input wire clk_i,
	input wire ack_i,
	input wire [31:0] rdat_i,
	output reg cyc_o = 1'b0,
	output reg stb_o = 1'b0,
	output reg we_o = 1'b0,
	output reg [3:0] adr_o = 4'h0,
	output reg [3:0] sel_o = 4'h0,
	output reg [31:0] wdat_o = 32'h0
);
	// The request stays put until ack is sampled, then drops for a cycle.
	task automatic bus(input w, input [3:0] a, input [7:0] d, input [3:0] s, output [7:0] r);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= s;
		wdat_o <= {24'h0, d};
		do
			@(posedge clk_i);
		while (!ack_i);
		r = rdat_i[7:0];
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		@(posedge clk_i);
	endtask
endmodule // cpu_model

// ---- test/flash_protect_config_tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the configuration and protection block.
module flash_protect_config_tb;
	localparam [63:0] ALLOW = 64'hff5a3c18080c0a0f;
	reg clk_i = 1'b0, rst_i = 1'b1, array_write_i = 1'b0, cmd_valid_i = 1'b0;
	reg cmd_mass_i = 1'b0, special_mode_i = 1'b0, cmd_block_i = 1'b0, pv, e;
	reg [1:0] backdoor_key_enable_i = 2'h0, buffer_empty_flag_i = 2'h0;
	reg [1:0] cmd_complete_flag_i = 2'h0;
	reg [7:0] nv_prot_blk0_i, nv_prot_blk1_i, r, p, q;
	reg [15:0] cmd_addr_i = 16'h0, a;
	reg [31:0] rnd = 32'h519a22bc;
	wire cyc_i, stb_i, we_i, ack_o, cmd_accept_o, cmd_refuse_o, cmd_seq_start_o;
	wire key_write_o, array_read_invalid_o, irq_o;
	wire [3:0] adr_i, sel_i;
	wire [31:0] dat_i, dat_o;
	int fail_count = 0, tests_run = 0, cycles = 0;
	always #2.5 clk_i = ~clk_i;
	cpu_model cpu_model_i (.clk_i(clk_i), .ack_i(ack_o), .rdat_i(dat_o), .cyc_o(cyc_i),
		.stb_o(stb_i), .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i), .wdat_o(dat_i));
	flash_protect_config flash_protect_config_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .special_mode_i(special_mode_i),
		.backdoor_key_enable_i(backdoor_key_enable_i), .nv_prot_blk0_i(nv_prot_blk0_i),
		.nv_prot_blk1_i(nv_prot_blk1_i), .buffer_empty_flag_i(buffer_empty_flag_i),
		.cmd_complete_flag_i(cmd_complete_flag_i), .array_write_i(array_write_i),
		.cmd_valid_i(cmd_valid_i), .cmd_block_i(cmd_block_i), .cmd_mass_i(cmd_mass_i),
		.cmd_addr_i(cmd_addr_i), .cmd_accept_o(cmd_accept_o), .cmd_refuse_o(cmd_refuse_o),
		.cmd_seq_start_o(cmd_seq_start_o), .key_write_o(key_write_o),
		.array_read_invalid_o(array_read_invalid_o), .irq_o(irq_o));
	function automatic [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic [2:0] sc(input [7:0] x);
		sc = {x[7], x[5], x[2]};
	endfunction
	// Next protection value; size fields follow the old disable bits.
	function automatic [7:0] nxt(input [7:0] o, input [7:0] w);
		nxt = o;
		if (ALLOW[{sc(o), sc(w)}])
			nxt = {w[7], o[6], w[5], o[5] ? w[4:3] : o[4:3], w[2], o[2] ? w[1:0] : o[1:0]};
	endfunction
	// Whether a program, erase or mass erase must be refused.
	function automatic prt(input [7:0] q, input [15:0] d, input m);
		logic hi, lo;
		hi = {1'b0, d} >= 17'h10000 - (17'h800 << q[4:3]);
		lo = d >= 16'h4000 && d < 16'h4000 + (16'h400 << q[1:0]);
		prt = m ? !(q[7] & q[5] & q[2]) : q[7] == ((!q[5] && hi) || (!q[2] && lo));
	endfunction
	task chk(input [7:0] got, input [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task chk1(input got, input exp);
		chk({7'h0, got}, {7'h0, exp});
	endtask
	task wr(input [3:0] ad, input [7:0] d);
		cpu_model_i.bus(1'b1, ad, d, 4'hf, r);
	endtask
	task rc(input [3:0] ad, input [7:0] x);
		cpu_model_i.bus(1'b0, ad, 8'h0, 4'hf, r);
		chk(r, x);
	endtask
	task awp;
		@(posedge clk_i) array_write_i <= 1'b1;
		@(posedge clk_i) array_write_i <= 1'b0;
		#1;
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Cuts a hang short.
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fail_count++;
			close_out;
		end
	end
	// Main sequence.
	initial
	begin
		rnd = lfsr(rnd);
		nv_prot_blk0_i = rnd[7:0] | 8'ha4;
		nv_prot_blk1_i = rnd[15:8];
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rc(4'h4, nv_prot_blk0_i);
		wr(4'h0, 8'hff);
		rc(4'h0, 8'hc1);
		rc(4'h4, nv_prot_blk1_i);
		rc(4'h2, 8'h00);
		wr(4'hc, 8'h10);
		rc(4'hc, 8'h00);
		backdoor_key_enable_i <= 2'h2;
		wr(4'h0, 8'h20);
		rc(4'h0, 8'h20);
		awp;
		chk1(key_write_o, 1'b1);
		chk1(array_read_invalid_o, 1'b1);
		wr(4'h0, 8'h00);
		awp;
		chk1(cmd_seq_start_o, 1'b1);
		chk1(array_read_invalid_o, 1'b0);
		buffer_empty_flag_i <= 2'h2;
		wr(4'h0, 8'h40);
		#1 chk1(irq_o, 1'b0);
		wr(4'h0, 8'h80);
		buffer_empty_flag_i <= 2'h0;
		cmd_complete_flag_i <= 2'h1;
		#1 chk1(irq_o, 1'b1);
		wr(4'h0, 8'h40);
		#1 chk1(irq_o, 1'b1);
		wr(4'h0, 8'h00);
		cmd_complete_flag_i <= 2'h0;
		#1 chk1(irq_o, 1'b0);
		wr(4'h8, 8'h20);
		p = nv_prot_blk0_i;
		pv = 1'b0;
		repeat (40)
		begin
			rnd = lfsr(rnd);
			wr(4'h4, rnd[7:0]);
			p = nxt(p, rnd[7:0]);
			rc(4'h4, p);
			a = {rnd[31] ? 2'b11 : 2'b01, rnd[29:16]};
			e = prt(p, a, rnd[15:13] == 3'h0);
			pv = pv | e;
			cmd_valid_i <= 1'b1;
			cmd_mass_i <= rnd[15:13] == 3'h0;
			cmd_addr_i <= a;
			@(posedge clk_i) cmd_valid_i <= 1'b0;
			#1 chk1(cmd_refuse_o, e);
			chk1(cmd_accept_o, !e);
		end
		rc(4'h8, {2'h0, pv, 5'h0});
		// Write-all in special mode reaches both banks and both status flags.
		special_mode_i <= 1'b1;
		wr(4'hc, 8'h10);
		rc(4'hc, 8'h10);
		q = nv_prot_blk1_i;
		rnd = lfsr(rnd);
		wr(4'h4, rnd[7:0]);
		p = nxt(p, rnd[7:0]);
		q = nxt(q, rnd[7:0]);
		rc(4'h4, p);
		wr(4'h4, 8'h24);
		p = nxt(p, 8'h24);
		q = nxt(q, 8'h24);
		rc(4'h4, p);
		// A write without the low byte lane selected leaves the register alone.
		cpu_model_i.bus(1'b1, 4'h0, 8'h01, 4'he, r);
		rc(4'h0, 8'h00);
		wr(4'h0, 8'h01);
		rc(4'h4, q);
		e = prt(q, a, 1'b0);
		cmd_block_i <= 1'b1;
		cmd_valid_i <= 1'b1;
		cmd_mass_i <= 1'b0;
		cmd_addr_i <= a;
		@(posedge clk_i) cmd_valid_i <= 1'b0;
		#1 chk1(cmd_refuse_o, e);
		chk1(cmd_accept_o, !e);
		rc(4'h8, {2'h0, e, 5'h0});
		wr(4'h8, 8'h20);
		rc(4'h8, 8'h00);
		wr(4'h0, 8'h00);
		rc(4'h8, 8'h00);
		close_out;
	end
endmodule // flash_protect_config_tb
